// File: src/gpio_ports_regs.svh
// Register offsets, reset values and widths of the three GPIO ports.
// Assumes inclusion by bare name; definitions only.
`ifndef GPIO_PORTS_REGS_SVH
`define GPIO_PORTS_REGS_SVH

// ==========================================================================
// Data-space offsets
`define IO_SPACE_BASE 8'h20
`define IO_SPACE_LAST 6'h3F
`define PORT_B_PIN_LEVELS_OFS 8'h23
`define PORT_B_DIRECTION_OFS 8'h24
`define PORT_B_OUTPUT_LATCH_OFS 8'h25
`define PORT_C_PIN_LEVELS_OFS 8'h26
`define PORT_C_DIRECTION_OFS 8'h27
`define PORT_C_OUTPUT_LATCH_OFS 8'h28
`define PORT_D_PIN_LEVELS_OFS 8'h29
`define PORT_D_DIRECTION_OFS 8'h2A
`define PORT_D_OUTPUT_LATCH_OFS 8'h2B

// ==========================================================================
// Reset values and widths
`define PORT_DIRECTION_RESET 8'h00
`define PORT_OUTPUT_LATCH_RESET 8'h00
`define PORT_B_WIDTH 8
`define PORT_C_WIDTH 7
`define PORT_D_WIDTH 8

`endif

// File: src/gpio_ports_pkg.sv
// Types shared by the GPIO port block.
// Assumes nothing beyond a SystemVerilog compiler.
package gpio_ports_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [7:0] data_addr_t;
  typedef logic [5:0] io_addr_t;
  typedef enum logic [1:0] {
    SEL_PIN_LEVELS = 2'b00,
    SEL_DIRECTION = 2'b01,
    SEL_OUTPUT_LATCH = 2'b10,
    SEL_NONE = 2'b11
  } reg_sel_e;
endpackage

// File: src/gpio_port_slice.sv
// One GPIO port: direction, output latch, pin synchroniser and pad drive.
// Assumes access strobes already decoded and on ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_ports_regs.svh"
module gpio_port_slice #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic wr_pin_levels_in,
  input wire logic wr_direction_in,
  input wire logic wr_output_latch_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic global_pullup_disable_in,
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pin_levels_out,
  output logic [WIDTH-1:0] direction_out,
  output logic [WIDTH-1:0] output_latch_out,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe_out,
  output logic [WIDTH-1:0] pullup_en_out
);
  logic [WIDTH-1:0] direction_r, output_latch_r, output_latch_nxt;
  logic [WIDTH-1:0] sync1_r, sync2_r, sync3_r;
  logic [WIDTH-1:0] pullup_nxt;

  // ========================================================================
  // Next values
  // Write to pin levels toggles latch bits written as one
  assign output_latch_nxt = wr_pin_levels_in ? (output_latch_r ^ wr_data_in) : // RULE_02
                            wr_output_latch_in ? wr_data_in : output_latch_r;
  // Pull-up only for input with latch high, unless globally disabled
  assign pullup_nxt = ~direction_r & output_latch_r & {WIDTH{~global_pullup_disable_in}}; // RULE_08

  // Port registers, clear on reset
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      direction_r <= WIDTH'(`PORT_DIRECTION_RESET); // RULE_03
      output_latch_r <= WIDTH'(`PORT_OUTPUT_LATCH_RESET); // RULE_03
    end else begin
      if (wr_direction_in) begin
        direction_r <= wr_data_in;
      end
      output_latch_r <= output_latch_nxt;
    end
  end

  // Pin synchroniser, three stages; first read only by second
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_levels_out <= '0;
    end else begin
      sync1_r <= pad_in; // RULE_10
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // Accept a change once stages two and three agree
      pin_levels_out <= (sync2_r & sync3_r) | (pin_levels_out & (sync2_r | sync3_r)); // RULE_04
    end
  end

  // Registered pad drive, direction bit n enables pin n
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      direction_out <= '0;
      output_latch_out <= '0;
      pad_out <= '0;
      pad_oe_out <= '0;
      pullup_en_out <= '0;
    end else begin
      direction_out <= wr_direction_in ? wr_data_in : direction_r;
      output_latch_out <= output_latch_nxt;
      pad_out <= output_latch_nxt;
      pad_oe_out <= wr_direction_in ? wr_data_in : direction_r; // RULE_06
      pullup_en_out <= pullup_nxt;
    end
  end
endmodule
`default_nettype wire

// File: src/three_port_gpio_registers.sv
// Three GPIO ports (B, C, D) behind the internal I/O bus of the core.
// Assumes a single-cycle bus on ref_clk_in: strobes with address, write data,
// registered read data; the pull-up disable level comes from control logic.
//
// Operation
// (RULE_01) Decode data-space offsets, and I/O offsets 0x20 lower within 0x00-0x3F.
// (RULE_02) Writing a pin levels register toggles output latch bits written one.
// (RULE_03) Reset clears every direction and output latch register to 0x00.
// (RULE_04) Pin levels have no reset value, follow pins; port B's at 0x23. Here reset clears pin levels and synchroniser stages to 0.
// (RULE_05) Port C implements bits 6:0 only; bit 7 unimplemented everywhere.
// (RULE_06) Ports B and D are eight bits; direction bit n drives pin n.
// (RULE_07) Each port has pin levels, direction, latch at consecutive addresses.
// (RULE_08) Global pull-up disable turns off all pull-ups, even direction/data 0b01.
// (RULE_09) Port B output latch sits at 0x25, resets to 0x00.
// (RULE_10) Pin levels pass a multi-stage synchroniser on the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_ports_regs.svh"
module three_port_gpio_registers #(
  parameter int B_WIDTH = `PORT_B_WIDTH,
  parameter int C_WIDTH = `PORT_C_WIDTH,
  parameter int D_WIDTH = `PORT_D_WIDTH
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic data_space_rd_in,
  input wire logic data_space_wr_in,
  input wire gpio_ports_pkg::data_addr_t data_space_addr_in,
  input wire logic io_space_rd_in,
  input wire logic io_space_wr_in,
  input wire gpio_ports_pkg::io_addr_t io_space_addr_in,
  input wire gpio_ports_pkg::byte_t bus_wdata_in,
  input wire logic global_pullup_disable_in,
  input wire logic [B_WIDTH-1:0] port_b_pad_in,
  input wire logic [C_WIDTH-1:0] port_c_pad_in,
  input wire logic [D_WIDTH-1:0] port_d_pad_in,
  output gpio_ports_pkg::byte_t bus_rdata_out,
  output logic bus_hit_out,
  output logic [B_WIDTH-1:0] port_b_pad_out,
  output logic [B_WIDTH-1:0] port_b_pad_oe_out,
  output logic [B_WIDTH-1:0] port_b_pullup_en_out,
  output logic [C_WIDTH-1:0] port_c_pad_out,
  output logic [C_WIDTH-1:0] port_c_pad_oe_out,
  output logic [C_WIDTH-1:0] port_c_pullup_en_out,
  output logic [D_WIDTH-1:0] port_d_pad_out,
  output logic [D_WIDTH-1:0] port_d_pad_oe_out,
  output logic [D_WIDTH-1:0] port_d_pullup_en_out
);
  import gpio_ports_pkg::*;

  // ========================================================================
  // Address decode
  // Maps a data-space offset onto a port and register
  function automatic logic [3:0] decode(input data_addr_t a);
    logic [3:0] r;
    r = {2'b11, SEL_NONE};
    unique case (a)
      `PORT_B_PIN_LEVELS_OFS: r = {2'b00, SEL_PIN_LEVELS}; // RULE_04
      `PORT_B_DIRECTION_OFS: r = {2'b00, SEL_DIRECTION}; // RULE_07
      `PORT_B_OUTPUT_LATCH_OFS: r = {2'b00, SEL_OUTPUT_LATCH}; // RULE_09
      `PORT_C_PIN_LEVELS_OFS: r = {2'b01, SEL_PIN_LEVELS};
      `PORT_C_DIRECTION_OFS: r = {2'b01, SEL_DIRECTION};
      `PORT_C_OUTPUT_LATCH_OFS: r = {2'b01, SEL_OUTPUT_LATCH};
      `PORT_D_PIN_LEVELS_OFS: r = {2'b10, SEL_PIN_LEVELS};
      `PORT_D_DIRECTION_OFS: r = {2'b10, SEL_DIRECTION};
      `PORT_D_OUTPUT_LATCH_OFS: r = {2'b10, SEL_OUTPUT_LATCH};
      default: r = {2'b11, SEL_NONE};
    endcase
    return r;
  endfunction

  // Merge both address forms; I/O address plus 0x20 gives the data offset
  wire logic use_io = io_space_rd_in | io_space_wr_in;
  wire data_addr_t io_as_data = 8'({2'b00, io_space_addr_in} + `IO_SPACE_BASE); // RULE_01
  wire data_addr_t eff_addr = use_io ? io_as_data : data_space_addr_in; // RULE_01
  wire logic any_wr = data_space_wr_in | io_space_wr_in;
  wire logic any_rd = data_space_rd_in | io_space_rd_in;
  wire logic [3:0] dec = decode(eff_addr);
  wire logic [1:0] port_sel = dec[3:2];
  wire reg_sel_e reg_sel = reg_sel_e'(dec[1:0]);
  wire logic hit = (reg_sel != SEL_NONE);

  // Per-port write strobes
  wire logic [2:0] port_hit = {port_sel == 2'b10, port_sel == 2'b01, port_sel == 2'b00};
  wire logic [2:0] wr_pin = port_hit & {3{any_wr & (reg_sel == SEL_PIN_LEVELS)}}; // RULE_02
  wire logic [2:0] wr_dir = port_hit & {3{any_wr & (reg_sel == SEL_DIRECTION)}};
  wire logic [2:0] wr_lat = port_hit & {3{any_wr & (reg_sel == SEL_OUTPUT_LATCH)}};

  // ========================================================================
  // Port instances
  logic [B_WIDTH-1:0] b_pin, b_dir, b_lat;
  logic [C_WIDTH-1:0] c_pin, c_dir, c_lat;
  logic [D_WIDTH-1:0] d_pin, d_dir, d_lat;

  gpio_port_slice #(.WIDTH(B_WIDTH)) u_port_b (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wr_pin_levels_in(wr_pin[0]),
    .wr_direction_in(wr_dir[0]),
    .wr_output_latch_in(wr_lat[0]),
    .wr_data_in(bus_wdata_in[B_WIDTH-1:0]), // RULE_06
    .global_pullup_disable_in(global_pullup_disable_in),
    .pad_in(port_b_pad_in),
    .pin_levels_out(b_pin),
    .direction_out(b_dir),
    .output_latch_out(b_lat),
    .pad_out(port_b_pad_out),
    .pad_oe_out(port_b_pad_oe_out),
    .pullup_en_out(port_b_pullup_en_out)
  );

  gpio_port_slice #(.WIDTH(C_WIDTH)) u_port_c (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wr_pin_levels_in(wr_pin[1]),
    .wr_direction_in(wr_dir[1]),
    .wr_output_latch_in(wr_lat[1]),
    .wr_data_in(bus_wdata_in[C_WIDTH-1:0]), // RULE_05
    .global_pullup_disable_in(global_pullup_disable_in),
    .pad_in(port_c_pad_in),
    .pin_levels_out(c_pin),
    .direction_out(c_dir),
    .output_latch_out(c_lat),
    .pad_out(port_c_pad_out),
    .pad_oe_out(port_c_pad_oe_out),
    .pullup_en_out(port_c_pullup_en_out)
  );

  gpio_port_slice #(.WIDTH(D_WIDTH)) u_port_d (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wr_pin_levels_in(wr_pin[2]),
    .wr_direction_in(wr_dir[2]),
    .wr_output_latch_in(wr_lat[2]),
    .wr_data_in(bus_wdata_in[D_WIDTH-1:0]), // RULE_06
    .global_pullup_disable_in(global_pullup_disable_in),
    .pad_in(port_d_pad_in),
    .pin_levels_out(d_pin),
    .direction_out(d_dir),
    .output_latch_out(d_lat),
    .pad_out(port_d_pad_out),
    .pad_oe_out(port_d_pad_oe_out),
    .pullup_en_out(port_d_pullup_en_out)
  );

  // ========================================================================
  // Read path
  // Zero-extends a port value to a byte; unimplemented bits read zero
  function automatic byte_t widen(input logic [7:0] v, input int w);
    byte_t m;
    m = 8'hFF >> (8 - w);
    return v & m;
  endfunction

  wire byte_t b_sel = widen(8'(reg_sel == SEL_PIN_LEVELS ? b_pin :
                               reg_sel == SEL_DIRECTION ? b_dir : b_lat), B_WIDTH);
  wire byte_t c_sel = widen(8'(reg_sel == SEL_PIN_LEVELS ? c_pin :
                               reg_sel == SEL_DIRECTION ? c_dir : c_lat), C_WIDTH); // RULE_05
  wire byte_t d_sel = widen(8'(reg_sel == SEL_PIN_LEVELS ? d_pin :
                               reg_sel == SEL_DIRECTION ? d_dir : d_lat), D_WIDTH);
  wire byte_t rd_mux = !hit ? 8'h00 :
                       port_sel == 2'b00 ? b_sel :
                       port_sel == 2'b01 ? c_sel : d_sel;

  // Registered read data and hit flag, one cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_rdata_out <= 8'h00;
      bus_hit_out <= 1'b0;
    end else begin
      bus_rdata_out <= any_rd ? rd_mux : 8'h00;
      bus_hit_out <= (any_rd | any_wr) & hit;
    end
  end
endmodule
`default_nettype wire

// File: test/gpio_pad_model.sv
// Pad model: pin driven by the port, else pulled up or floating.
// Assumes registered port drive on the block's clock.
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic [W-1:0] drv_in,
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] pu_in,
  output logic [W-1:0] lvl_out
);
  // ==========
  // Pad levels
  logic ph = 1'b0;
  // Undriven pins without pull-up wobble each cycle
  always @(posedge clk_in) begin
    ph <= ~ph;
  end
  // Driven pins follow the latch
  assign lvl_out = (oe_in & drv_in) | (~oe_in & (pu_in | {W{ph}}));
endmodule
`default_nettype wire

// File: test/gpio_regs_chk.sv
// Port-level checker of the three-port register block.
// Assumes bind onto the block with default port widths.
`timescale 1ns/10ps
`default_nettype none
module gpio_regs_chk (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic data_space_rd_in,
  input wire logic data_space_wr_in,
  input wire gpio_ports_pkg::data_addr_t data_space_addr_in,
  input wire logic io_space_rd_in,
  input wire logic io_space_wr_in,
  input wire gpio_ports_pkg::io_addr_t io_space_addr_in,
  input wire gpio_ports_pkg::byte_t bus_wdata_in,
  input wire logic global_pullup_disable_in,
  input wire gpio_ports_pkg::byte_t bus_rdata_out,
  input wire logic bus_hit_out,
  input wire logic [7:0] port_b_pad_out,
  input wire logic [7:0] port_b_pad_oe_out,
  input wire logic [7:0] port_b_pullup_en_out,
  input wire logic [6:0] port_c_pullup_en_out,
  input wire logic [7:0] port_d_pad_out
);
  // ==========
  // Properties
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Access kind decode
  wire io_any = io_space_rd_in | io_space_wr_in;
  wire d_any = data_space_rd_in | data_space_wr_in;
  wire dsel = d_any & !io_any;
  a_data_hit: assert property (p_data_hit) else $error("no hit on data access");
  property p_data_hit;
    dsel && data_space_addr_in inside {[8'h23:8'h2B]} |=> bus_hit_out;
  endproperty
  a_io_hit: assert property (p_io_hit) else $error("no hit on io access");
  property p_io_hit;
    io_any && io_space_addr_in inside {[6'h03:6'h0B]} |=> bus_hit_out;
  endproperty
  a_idle: assert property (p_idle) else $error("bus answer without access");
  property p_idle;
    !io_any && !d_any |=> !bus_hit_out && bus_rdata_out == 8'h00;
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin write did not toggle");
  property p_toggle;
    dsel && data_space_wr_in && data_space_addr_in == 8'h23
      |=> port_b_pad_out == ($past(port_b_pad_out) ^ $past(bus_wdata_in));
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("direction not on enables");
  property p_dir_b;
    io_space_wr_in && io_space_addr_in == 6'h04 |=> port_b_pad_oe_out == $past(bus_wdata_in);
  endproperty
  a_latch_d: assert property (p_latch_d) else $error("latch not on pads");
  property p_latch_d;
    io_space_wr_in && io_space_addr_in == 6'h0B |=> port_d_pad_out == $past(bus_wdata_in);
  endproperty
  a_c_top: assert property (p_c_top) else $error("port c bit 7 read one");
  property p_c_top;
    dsel && data_space_rd_in && data_space_addr_in inside {[8'h26:8'h28]} |=> !bus_rdata_out[7];
  endproperty
  a_pud: assert property (p_pud) else $error("pull-up on while disabled");
  property p_pud;
    global_pullup_disable_in [*3] |-> port_b_pullup_en_out == 0 && port_c_pullup_en_out == 0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_reset;
    $rose(reset_n_in) |-> port_b_pad_oe_out == 0 && port_b_pad_out == 0 && port_d_pad_out == 0;
  endproperty
endmodule
bind three_port_gpio_registers gpio_regs_chk i_chk (.*);
`default_nettype wire

// File: test/test_three_port_gpio_registers.sv
// Bench of the three-port register block: bus tasks and pad models.
// Assumes package, block, checker and pad model compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_three_port_gpio_registers;
  import gpio_ports_pkg::*;
  // ==========
  // Design and pads
  logic clk, rst_n, d_rd, d_wr, i_rd, i_wr, global_pullup_disable;
  data_addr_t d_a;
  io_addr_t i_a;
  byte_t wd, q;
  wire byte_t rd;
  wire hit;
  wire [7:0] b_o, b_oe, b_pu, b_in, d_o, d_oe, d_pu, d_in;
  wire [6:0] c_o, c_oe, c_pu, c_in;
  int num_errors = 0;
  int total_checks = 0;
  byte_t ofs[6] = '{8'h24, 8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B};
  byte_t msk[6] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hFF, 8'hFF};
  three_port_gpio_registers i_dut (.ref_clk_in(clk), .reset_n_in(rst_n),
    .data_space_rd_in(d_rd), .data_space_wr_in(d_wr), .data_space_addr_in(d_a),
    .io_space_rd_in(i_rd), .io_space_wr_in(i_wr), .io_space_addr_in(i_a),
    .bus_wdata_in(wd), .global_pullup_disable_in(global_pullup_disable), .port_b_pad_in(b_in),
    .port_c_pad_in(c_in), .port_d_pad_in(d_in), .bus_rdata_out(rd), .bus_hit_out(hit),
    .port_b_pad_out(b_o), .port_b_pad_oe_out(b_oe), .port_b_pullup_en_out(b_pu),
    .port_c_pad_out(c_o), .port_c_pad_oe_out(c_oe), .port_c_pullup_en_out(c_pu),
    .port_d_pad_out(d_o), .port_d_pad_oe_out(d_oe), .port_d_pullup_en_out(d_pu));
  gpio_pad_model #(.W(8)) i_pb (.clk_in(clk), .drv_in(b_o), .oe_in(b_oe), .pu_in(b_pu),
    .lvl_out(b_in));
  gpio_pad_model #(.W(7)) i_pc (.clk_in(clk), .drv_in(c_o), .oe_in(c_oe), .pu_in(c_pu),
    .lvl_out(c_in));
  gpio_pad_model #(.W(8)) i_pd (.clk_in(clk), .drv_in(d_o), .oe_in(d_oe), .pu_in(d_pu),
    .lvl_out(d_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // One bus access, answer taken one cycle later
  task automatic xfer(input logic io, input logic wr, input byte_t a, input byte_t v,
                      input logic h);
    @(posedge clk);
    #1;
    {i_rd, i_wr, d_rd, d_wr} = {io & !wr, io & wr, !io & !wr, !io & wr};
    d_a = a;
    i_a = 6'(a - 8'h20);
    wd = v;
    @(posedge clk);
    #1;
    {i_rd, i_wr, d_rd, d_wr} = 4'h0;
    q = rd;
    `CHK("hit", h, hit)
  endtask
  task automatic chk_rd(input logic io, input byte_t a, input byte_t e, input logic h);
    xfer(io, 1'b0, a, 8'h00, h);
    `CHK("rdata", e, q)
  endtask
  task automatic test_done;
    $display("TB: checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    #4000;
    num_errors++;
    test_done;
  end
  // Main sequence
  initial begin
    {d_rd, d_wr, i_rd, i_wr, global_pullup_disable, rst_n} = 6'h00;
    d_a = 8'h00;
    i_a = 6'h00;
    wd = 8'h00;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (ofs[k]) chk_rd(1'b0, ofs[k], 8'h00, 1'b1);
    foreach (ofs[k]) xfer(1'b1, 1'b1, ofs[k], 8'hFF, 1'b1);
    foreach (ofs[k]) chk_rd(1'b0, ofs[k], msk[k], 1'b1);
    `CHK("b_oe", 8'hFF, b_oe)
    `CHK("d_oe", 8'hFF, d_oe)
    `CHK("c_oe", 7'h7F, c_oe)
    `CHK("d_pu", 8'h00, d_pu)
    `CHK("c_o", 7'h7F, c_o)
    xfer(1'b0, 1'b1, 8'h23, 8'h0F, 1'b1);
    `CHK("b_o", 8'hF0, b_o)
    chk_rd(1'b0, 8'h25, 8'hF0, 1'b1);
    repeat (4) @(posedge clk);
    chk_rd(1'b0, 8'h23, 8'hF0, 1'b1);
    xfer(1'b1, 1'b1, 8'h23, 8'hFF, 1'b1);
    chk_rd(1'b0, 8'h23, 8'hF0, 1'b1);
    repeat (4) @(posedge clk);
    chk_rd(1'b1, 8'h23, 8'h0F, 1'b1);
    xfer(1'b0, 1'b1, 8'h2C, 8'h55, 1'b0);
    chk_rd(1'b0, 8'h2C, 8'h00, 1'b0);
    chk_rd(1'b1, 8'h22, 8'h00, 1'b0);
    xfer(1'b1, 1'b1, 8'h27, 8'h00, 1'b1);
    repeat (2) @(posedge clk);
    #1 `CHK("c_pu", 7'h7F, c_pu)
    global_pullup_disable = 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("c_pu", 7'h00, c_pu)
    `CHK("b_pu", 8'h00, b_pu)
    // Mid-run reset clears drive and registers again
    rst_n = 1'b0;
    #1 `CHK("b_oe", 8'h00, b_oe)
    `CHK("d_o", 8'h00, d_o)
    @(posedge clk);
    #1 rst_n = 1'b1;
    chk_rd(1'b1, 8'h2B, 8'h00, 1'b1);
    chk_rd(1'b0, 8'h27, 8'h00, 1'b1);
    test_done;
  end
endmodule
`default_nettype wire
